// [pkg/accreg_regs.svh]
// Purpose: register offsets, field positions and reset values of the accelerometer register bank
// Assumes: 7-bit register address space, bit 7 of the command byte is the direction flag
// Notes: definitions only
`ifndef ACCREG_REGS_SVH
`define ACCREG_REGS_SVH

// Direction flag in the command byte
`define ACCREG_DIR_BIT 7
// Read-only axis outputs, identity and status
`define ACCREG_X_HP_LO 7'h00
`define ACCREG_X_HP_HI 7'h01
`define ACCREG_Y_HP_LO 7'h02
`define ACCREG_Y_HP_HI 7'h03
`define ACCREG_Z_HP_LO 7'h04
`define ACCREG_Z_HP_HI 7'h05
`define ACCREG_X_AC_LO 7'h06
`define ACCREG_X_AC_HI 7'h07
`define ACCREG_Y_AC_LO 7'h08
`define ACCREG_Y_AC_HI 7'h09
`define ACCREG_Z_AC_LO 7'h0a
`define ACCREG_Z_AC_HI 7'h0b
`define ACCREG_COMM_CHECK 7'h0c
`define ACCREG_PART_ID 7'h0f
`define ACCREG_ORIENT_CUR 7'h10
`define ACCREG_ORIENT_PRE 7'h11
`define ACCREG_EVT_SRC_A 7'h15
`define ACCREG_EVT_SRC_B 7'h16
`define ACCREG_FLAG_SUM 7'h18
`define ACCREG_EVT_RELEASE 7'h1a
// Read/write configuration, except the read-only queue status and port and the write-only flush
`define ACCREG_MAIN_CFG_A 7'h1b
`define ACCREG_MAIN_CFG_B 7'h1c
`define ACCREG_MAIN_CFG_C 7'h1d
`define ACCREG_EVT_CFG_A 7'h1e
`define ACCREG_EVT_CFG_B 7'h1f
`define ACCREG_EVT_CFG_C 7'h20
`define ACCREG_RATE_CFG 7'h21
`define ACCREG_ORIENT_DEB 7'h28
`define ACCREG_WAKE_DEB 7'h29
`define ACCREG_KNOCK_IVL 7'h2b
`define ACCREG_KNOCK_UPPER 7'h2c
`define ACCREG_KNOCK_LOWER 7'h2d
`define ACCREG_KNOCK_PULSE 7'h2e
`define ACCREG_KNOCK_TOTAL 7'h2f
`define ACCREG_KNOCK_LAT 7'h30
`define ACCREG_KNOCK_SECOND 7'h31
`define ACCREG_QUEUE_CFG_A 7'h32
`define ACCREG_QUEUE_CFG_B 7'h33
`define ACCREG_QUEUE_ST_A 7'h34
`define ACCREG_QUEUE_ST_B 7'h35
`define ACCREG_QUEUE_FLUSH 7'h36
`define ACCREG_SENSE_TEST 7'h3a
`define ACCREG_WAKE_LIMIT 7'h5a
`define ACCREG_ORIENT_ANGLE 7'h5c
`define ACCREG_ORIENT_HYST 7'h6f
`define ACCREG_QUEUE_PORT 7'h7f
// Fields of main_config_a
`define ACCREG_OPER_EN_BIT 7
`define ACCREG_RES_SEL_BIT 6
`define ACCREG_WAKE_EN_BIT 1
// Field of sample_rate_config
`define ACCREG_RATE_MSB 2
`define ACCREG_RATE_LSB 0
// Reset value of every read/write register
`define ACCREG_RW_RESET 8'h00
// Frame length in serial clocks
`define ACCREG_FRAME_BITS 5'd16
`define ACCREG_ADDR_BITS 5'd8

`endif

// [pkg/accreg_pkg.sv]
// Purpose: types shared by the accelerometer register bank
// Assumes: nothing beyond the register header
// Notes: constants live in accreg_regs.svh
`default_nettype none
package accreg_pkg;
  typedef enum logic [1:0] {
    ACCREG_IDLE,
    ACCREG_ADDR,
    ACCREG_DATA
  } accreg_state_e;
  typedef logic [11:0] accreg_axis_t;
endpackage : accreg_pkg
`default_nettype wire

// [rtl/accreg_top.sv]
// Purpose: register bank of a three-axis accelerometer behind a 4-wire serial slave port
// Assumes: serial clock, select and data arrive asynchronously and are oversampled by clk_sys
// Notes: one register per frame: address byte then data byte, MSB first
// Notes on behaviour
// - Forty-six byte-wide registers, 7-bit address space
// - Decode each register at its address, honour access
// - Twelve valid bits or eight, by resolution select
// - Refresh outputs once per configured sample period
// - Hold outputs during an axis register read, defer new sample
// - Outputs are two's complement, sign kept
// - Address MSB zero writes, one reads
// - High-pass outputs valid only with wake enabled
`include "accreg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module accreg_top
  import accreg_pkg::*;
#(
  parameter int ODR_BASE_CYC = 125000,
  parameter logic [7:0] PART_ID_VAL = 8'h5a,
  parameter logic [7:0] COMM_CHECK_VAL = 8'h55
) (
  input wire logic clk_sys,
  input wire logic srst,
  // Serial pins, asynchronous to clk_sys
  input wire logic sclk,
  input wire logic ncs_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe_n,
  // Axis words from the conditioning path, same clock
  input wire accreg_axis_t x_accel,
  input wire accreg_axis_t y_accel,
  input wire accreg_axis_t z_accel,
  input wire accreg_axis_t x_highpass,
  input wire accreg_axis_t y_highpass,
  input wire accreg_axis_t z_highpass,
  // Live status and queue bytes, read as the address byte ends
  input wire logic [7:0] orient_cur,
  input wire logic [7:0] orient_pre,
  input wire logic [7:0] event_src_a,
  input wire logic [7:0] event_src_b,
  input wire logic [7:0] flag_sum,
  input wire logic [7:0] queue_state_a,
  input wire logic [7:0] queue_state_b,
  input wire logic [7:0] queue_data,
  // Side-effect strobes and configuration levels
  output logic queue_flush,
  output logic queue_pop,
  output logic event_release,
  output logic operating_enable,
  output logic resolution_select,
  output logic wake_enable,
  output logic [7:0] cfg_view [0:127]
);

  // The base period is shifted by the rate field; a wider rate field would overflow
  initial begin
    if (ODR_BASE_CYC < 1 || ODR_BASE_CYC > 16777215) begin
      $error("ODR_BASE_CYC out of range");
    end
    // Byte views split a twelve-bit word; another width would not fit them
    if ($bits(accreg_axis_t) != 12) begin
      $error("axis word must be twelve bits");
    end
  end

  // Two-flop synchronisers for the serial pins
  logic [1:0] sclk_sync_r;
  logic [1:0] ncs_sync_r;
  logic [1:0] sdi_sync_r;
  logic sclk_prev_r;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sclk_sync_r <= 2'h0;
      ncs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], sclk};
      ncs_sync_r <= {ncs_sync_r[0], ncs_n};
      sdi_sync_r <= {sdi_sync_r[0], sdi};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel;
  // Edges only count while selected, so a free-running clock does no harm
  assign sclk_rise = sel && sclk_sync_r[1] && !sclk_prev_r;
  assign sclk_fall = sel && !sclk_sync_r[1] && sclk_prev_r;
  assign sel = !ncs_sync_r[1];

  // Frame sequencer
  accreg_state_e state_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] rx_r;
  logic [7:0] tx_r;
  logic [6:0] addr_r;
  logic is_read_r;
  logic [7:0] rd_data;
  logic [7:0] rx_nxt;
  logic wr_commit;
  logic addr_done;
  // Shift value including the bit taken at this rising edge
  assign rx_nxt = {rx_r[6:0], sdi_sync_r[1]};
  // Address byte ends at the eighth rising edge
  assign addr_done = sclk_rise && state_r == ACCREG_ADDR && bit_cnt_r == `ACCREG_ADDR_BITS - 5'd1;
  // Write lands at the sixteenth rising edge, before deselect
  assign wr_commit = sclk_rise && state_r == ACCREG_DATA && !is_read_r
    && bit_cnt_r == `ACCREG_FRAME_BITS - 5'd1;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ACCREG_IDLE;
      bit_cnt_r <= 5'h00;
      rx_r <= 8'h00;
      addr_r <= 7'h00;
      is_read_r <= 1'b0;
    end else if (!sel) begin
      state_r <= ACCREG_IDLE;
      bit_cnt_r <= 5'h00;
    end else begin
      case (state_r)
        ACCREG_IDLE: begin
          state_r <= ACCREG_ADDR;
        end
        ACCREG_ADDR: begin
          if (sclk_rise) begin
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 5'd1;
            if (addr_done) begin
              addr_r <= rx_nxt[6:0];
              is_read_r <= rx_nxt[`ACCREG_DIR_BIT];
              state_r <= ACCREG_DATA;
            end
          end
        end
        ACCREG_DATA: begin
          // Extra clocks after the data byte are ignored
          if (sclk_rise && bit_cnt_r < `ACCREG_FRAME_BITS) begin
            rx_r <= rx_nxt;
            bit_cnt_r <= bit_cnt_r + 5'd1;
          end
        end
        default: begin
          state_r <= ACCREG_IDLE;
        end
      endcase
    end
  end

  // Output shifter: first bit on the falling edge after the address byte
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_r <= 8'h00;
      sdo_o <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (!sel) begin
      sdo_oe_n <= 1'b1;
    end else if (addr_done && rx_nxt[`ACCREG_DIR_BIT]) begin
      tx_r <= rd_data;
    end else if (sclk_fall && state_r == ACCREG_DATA && is_read_r
        && bit_cnt_r < `ACCREG_FRAME_BITS) begin
      sdo_o <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
      sdo_oe_n <= 1'b0;
    end
  end

  // Read/write configuration storage, indexed by address
  logic [7:0] cfg_r [0:127];
  function automatic logic is_rw(input logic [6:0] a);
    case (a)
      `ACCREG_MAIN_CFG_A, `ACCREG_MAIN_CFG_B, `ACCREG_MAIN_CFG_C,
      `ACCREG_EVT_CFG_A, `ACCREG_EVT_CFG_B, `ACCREG_EVT_CFG_C,
      `ACCREG_RATE_CFG, `ACCREG_ORIENT_DEB, `ACCREG_WAKE_DEB,
      `ACCREG_KNOCK_IVL, `ACCREG_KNOCK_UPPER, `ACCREG_KNOCK_LOWER,
      `ACCREG_KNOCK_PULSE, `ACCREG_KNOCK_TOTAL, `ACCREG_KNOCK_LAT,
      `ACCREG_KNOCK_SECOND, `ACCREG_QUEUE_CFG_A, `ACCREG_QUEUE_CFG_B,
      `ACCREG_SENSE_TEST, `ACCREG_WAKE_LIMIT, `ACCREG_ORIENT_ANGLE,
      `ACCREG_ORIENT_HYST: is_rw = 1'b1;
      default: is_rw = 1'b0;
    endcase
  endfunction : is_rw

  // Only writable addresses take data; protected writes are left to the master
  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_cfg
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          cfg_r[gi] <= `ACCREG_RW_RESET;
        end else if (wr_commit && addr_r == 7'(gi) && is_rw(7'(gi))) begin
          cfg_r[gi] <= rx_nxt;
        end
      end
      assign cfg_view[gi] = is_rw(7'(gi)) ? cfg_r[gi] : 8'h00;
    end
  endgenerate

  // Level outputs straight from the stored main config byte
  assign operating_enable = cfg_r[`ACCREG_MAIN_CFG_A][`ACCREG_OPER_EN_BIT];
  assign resolution_select = cfg_r[`ACCREG_MAIN_CFG_A][`ACCREG_RES_SEL_BIT];
  assign wake_enable = cfg_r[`ACCREG_MAIN_CFG_A][`ACCREG_WAKE_EN_BIT];

  // Side-effect strobes: flush on write, pop and release on read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      queue_flush <= 1'b0;
      queue_pop <= 1'b0;
      event_release <= 1'b0;
    end else begin
      queue_flush <= wr_commit && addr_r == `ACCREG_QUEUE_FLUSH;
      queue_pop <= addr_done && rx_nxt == {1'b1, `ACCREG_QUEUE_PORT};
      event_release <= addr_done && rx_nxt == {1'b1, `ACCREG_EVT_RELEASE};
    end
  end

  // Sample period divider; off while operation is disabled
  logic [31:0] odr_cnt_r;
  logic [31:0] odr_period;
  logic odr_tick;
  // Each step of the rate field doubles the period; the range check keeps it in 32 bits
  assign odr_period = 32'(ODR_BASE_CYC) << cfg_r[`ACCREG_RATE_CFG][`ACCREG_RATE_MSB:`ACCREG_RATE_LSB];
  assign odr_tick = operating_enable && odr_cnt_r >= odr_period - 32'd1;
  always_ff @(posedge clk_sys) begin
    if (srst || !operating_enable || odr_tick) begin
      odr_cnt_r <= 32'h0;
    end else begin
      odr_cnt_r <= odr_cnt_r + 32'd1;
    end
  end

  // Output hold: a read frame on an axis register freezes the outputs until deselect
  logic out_hold_r;
  // Reads of other registers never stall sampling
  always_ff @(posedge clk_sys) begin
    if (srst || !sel) begin
      out_hold_r <= 1'b0;
    end else if (addr_done && rx_nxt[`ACCREG_DIR_BIT] && rx_nxt[6:0] <= `ACCREG_Z_AC_HI) begin
      out_hold_r <= 1'b1;
    end
  end

  // A tick during a hold is remembered, not dropped; a tick that meets a capture leaves nothing pending
  logic pend_r;
  logic take;
  // The read that starts a hold also blocks the capture in its own cycle,
  // so the byte already shifting out and its partner byte stay a pair
  assign take = (pend_r || odr_tick) && !out_hold_r && !(addr_done && rx_nxt[6:0] <= `ACCREG_Z_AC_HI);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_r <= 1'b0;
    end else if (odr_tick) begin
      pend_r <= !take;
    end else if (take) begin
      pend_r <= 1'b0;
    end
  end

  // Captured axis words, raw and high-pass
  accreg_axis_t acc_r [0:5];
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < 6; i++) begin
        acc_r[i] <= 12'h000;
      end
    end else if (take) begin
      acc_r[0] <= x_highpass;
      acc_r[1] <= y_highpass;
      acc_r[2] <= z_highpass;
      acc_r[3] <= x_accel;
      acc_r[4] <= y_accel;
      acc_r[5] <= z_accel;
    end
  end

  // Byte views: sign in high byte, low nibble only at twelve-bit resolution
  function automatic logic [7:0] axis_byte(input accreg_axis_t d, input logic hi,
                                           input logic res12);
    if (hi) begin
      axis_byte = d[11:4];
    end else begin
      axis_byte = res12 ? {d[3:0], 4'h0} : 8'h00;
    end
  endfunction : axis_byte

  // Read multiplexer; write-only and unused addresses return zero
  logic [6:0] rd_addr;
  logic hp_ok;
  assign rd_addr = rx_nxt[6:0];
  assign hp_ok = wake_enable;

  // Axis slot of a read address: raw words sit after the three filtered ones
  logic [2:0] axis_slot;
  always_comb begin
    case (rd_addr)
      `ACCREG_X_HP_LO, `ACCREG_X_HP_HI: axis_slot = 3'd0;
      `ACCREG_Y_HP_LO, `ACCREG_Y_HP_HI: axis_slot = 3'd1;
      `ACCREG_Z_HP_LO, `ACCREG_Z_HP_HI: axis_slot = 3'd2;
      `ACCREG_X_AC_LO, `ACCREG_X_AC_HI: axis_slot = 3'd3;
      `ACCREG_Y_AC_LO, `ACCREG_Y_AC_HI: axis_slot = 3'd4;
      `ACCREG_Z_AC_LO, `ACCREG_Z_AC_HI: axis_slot = 3'd5;
      default: axis_slot = 3'd0;
    endcase
  end

  always_comb begin
    rd_data = 8'h00;
    if (rd_addr <= `ACCREG_Z_HP_HI) begin
      // Filtered words mean nothing without wake detection
      rd_data = hp_ok ? axis_byte(acc_r[axis_slot], rd_addr[0], resolution_select) : 8'h00;
    end else if (rd_addr <= `ACCREG_Z_AC_HI) begin
      // Odd addresses are the high bytes
      rd_data = axis_byte(acc_r[axis_slot], rd_addr[0], resolution_select);
    end else if (is_rw(rd_addr)) begin
      rd_data = cfg_r[rd_addr];
    end else begin
      case (rd_addr)
        `ACCREG_COMM_CHECK: rd_data = COMM_CHECK_VAL;
        `ACCREG_PART_ID: rd_data = PART_ID_VAL; // Arbitrary value
        `ACCREG_ORIENT_CUR: rd_data = orient_cur;
        `ACCREG_ORIENT_PRE: rd_data = orient_pre;
        `ACCREG_EVT_SRC_A: rd_data = event_src_a;
        `ACCREG_EVT_SRC_B: rd_data = event_src_b;
        `ACCREG_FLAG_SUM: rd_data = flag_sum;
        `ACCREG_QUEUE_ST_A: rd_data = queue_state_a;
        `ACCREG_QUEUE_ST_B: rd_data = queue_state_b;
        `ACCREG_QUEUE_PORT: rd_data = queue_data;
        default: rd_data = 8'h00;
      endcase
    end
  end

endmodule : accreg_top
`default_nettype wire

// [tb/accreg_top_properties.sv]
// Purpose: port-level checks of the register bank
// Assumes: single clock domain, srst synchronous
// Notes: bound to accreg_top below
`include "accreg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module accreg_top_properties (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ncs_n,
  input wire logic sdo_oe_n,
  input wire logic queue_flush,
  input wire logic queue_pop,
  input wire logic event_release,
  input wire logic operating_enable,
  input wire logic resolution_select,
  input wire logic wake_enable,
  input wire logic [7:0] cfg_view [0:127]
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic [7:0] ca;
  // Main config byte, watched for its level outputs
  assign ca = cfg_view[`ACCREG_MAIN_CFG_A];
  AST_OE_IDLE: assert property (ncs_n [*5] |-> sdo_oe_n)
    else $error("data out driven while deselected");
  AST_FLUSH_ONE: assert property (queue_flush |=> !queue_flush)
    else $error("flush strobe too long");
  AST_POP_ONE: assert property (queue_pop |=> !queue_pop)
    else $error("pop strobe too long");
  AST_REL_ONE: assert property (event_release |=> !event_release)
    else $error("release strobe too long");
  AST_READ_DRIVES: assert property ((queue_pop || event_release) |-> ##[1:16] !sdo_oe_n)
    else $error("read frame without data out");
  AST_CFG_LEVELS: assert property ($stable(ca) |->
    {operating_enable, resolution_select, wake_enable} == {ca[7], ca[6], ca[1]})
    else $error("config levels differ from stored byte");
  AST_UNMAPPED_ZERO: assert property (cfg_view[7'h00] == 8'h00 && cfg_view[7'h0d] == 8'h00
    && cfg_view[7'h36] == 8'h00 && cfg_view[7'h7f] == 8'h00)
    else $error("storage at non-writable address");
  AST_CFG_STILL: assert property (ncs_n [*5] |-> $stable(ca))
    else $error("config changed with no frame");
  // Main scenarios reached
  cover property ($fell(sdo_oe_n));
  cover property (queue_flush);
  cover property (event_release);
  cover property ($rose(operating_enable));
endmodule : accreg_top_properties
bind accreg_top accreg_top_properties accreg_top_properties_i (
  .clk_sys(clk_sys), .srst(srst), .ncs_n(ncs_n), .sdo_oe_n(sdo_oe_n), .queue_flush(queue_flush),
  .queue_pop(queue_pop), .event_release(event_release), .operating_enable(operating_enable),
  .resolution_select(resolution_select), .wake_enable(wake_enable), .cfg_view(cfg_view));
`default_nettype wire

// [tb/accreg_master_model.sv]
// Purpose: serial master that frames register reads and writes
// Assumes: mode 0, serial period of eight system clocks
// Notes: data line idles at the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module accreg_master_model (
  input wire logic clk_sys,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  output logic sclk,
  output logic ncs_n,
  output logic sdi
);
  // Serial clock stands low outside frames
  initial begin
    sclk = 1'b0;
    ncs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : hold
  // Command byte then data byte, MSB first
  task automatic frame(input logic [15:0] tx, output logic [7:0] rx);
    ncs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = tx[i];
      hold(4);
      sclk = 1'b1;
      hold(3);
      if (i < 8) rx[i] = sdo_oe_n ? 1'bx : sdo_o; // Late in high phase so the bit has settled
      hold(1);
      sclk = 1'b0;
    end
    hold(4);
    ncs_n = 1'b1;
    sdi = ~sdi; // Stale bit never looks valid
    hold(6);
  endtask : frame
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rx;
    frame({1'b0, a, d}, rx);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    frame({1'b1, a, 8'h00}, d);
  endtask : rd
endmodule : accreg_master_model
`default_nettype wire

// [tb/accreg_top_bench.sv]
// Purpose: self-checking bench of the register bank
// Assumes: sample period base shortened to 20 cycles
// Notes: prints only mismatches and the verdict
`include "accreg_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module accreg_top_bench;
  import accreg_pkg::*;
  localparam logic [7:0] PID = 8'h3c; // Arbitrary value
  localparam logic [7:0] CCK = 8'h6b; // Arbitrary value
  localparam logic [6:0] RW_A [22] = '{7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h20, 7'h21, 7'h28, 7'h29, 7'h2b,
    7'h2c, 7'h2d, 7'h2e, 7'h2f, 7'h30, 7'h31, 7'h32, 7'h33, 7'h3a, 7'h5a, 7'h5c, 7'h6f};
  localparam logic [6:0] RO_A [5] = '{7'h00, 7'h0d, 7'h12, 7'h7f, 7'h10};
  logic clk_sys, srst, sclk, ncs_n, sdi, sdo_o, sdo_oe_n, q_flush, q_pop, ev_rel;
  logic [7:0] live, rd;
  accreg_axis_t ax, hp;
  int err_total = 0;
  int tests_run = 0;
  int n_flush = 0;
  int n_pop = 0;
  int n_rel = 0;
  accreg_top #(.ODR_BASE_CYC(20), .PART_ID_VAL(PID), .COMM_CHECK_VAL(CCK)) accreg_top_i (
    .clk_sys(clk_sys), .srst(srst), .sclk(sclk), .ncs_n(ncs_n), .sdi(sdi), .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n), .x_accel(ax), .y_accel(~ax), .z_accel(ax), .x_highpass(hp), .y_highpass(hp),
    .z_highpass(~hp), .orient_cur(live), .orient_pre(~live), .event_src_a(live),
    .event_src_b(live ^ 8'h0f), .flag_sum(live), .queue_state_a(live), .queue_state_b(~live),
    .queue_data(live), .queue_flush(q_flush), .queue_pop(q_pop), .event_release(ev_rel),
    .operating_enable(), .resolution_select(), .wake_enable(), .cfg_view());
  accreg_master_model accreg_master_model_i (
    .clk_sys(clk_sys), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .sclk(sclk), .ncs_n(ncs_n), .sdi(sdi));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Strobe counts, judged after whole frames
  always @(posedge clk_sys) begin
    n_flush <= n_flush + (q_flush === 1'b1);
    n_pop <= n_pop + (q_pop === 1'b1);
    n_rel <= n_rel + (ev_rel === 1'b1);
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    accreg_master_model_i.rd(a, rd);
    check8(rd, exp);
  endtask : rchk
  task automatic t_reset_map;
    rchk(`ACCREG_PART_ID, PID);
    rchk(`ACCREG_COMM_CHECK, CCK);
    rchk(`ACCREG_MAIN_CFG_A, 8'h00);
  endtask : t_reset_map
  // Every writable register, then stray writes that must change nothing
  task automatic t_rw_table;
    foreach (RW_A[k]) accreg_master_model_i.wr(RW_A[k], {1'b0, RW_A[k]});
    foreach (RO_A[k]) accreg_master_model_i.wr(RO_A[k], 8'hff);
    foreach (RW_A[k]) rchk(RW_A[k], {1'b0, RW_A[k]});
    rchk(7'h0d, 8'h00);
  endtask : t_rw_table
  task automatic t_live;
    live = 8'ha7;
    check8(8'(n_pop), 8'h00);
    rchk(`ACCREG_ORIENT_CUR, 8'ha7);
    rchk(`ACCREG_ORIENT_PRE, 8'h58);
    rchk(`ACCREG_EVT_SRC_B, 8'ha8);
    rchk(`ACCREG_QUEUE_ST_B, 8'h58);
    rchk(`ACCREG_QUEUE_PORT, 8'ha7);
    rchk(`ACCREG_EVT_RELEASE, 8'h00);
    accreg_master_model_i.wr(`ACCREG_QUEUE_FLUSH, 8'hff);
    rchk(`ACCREG_QUEUE_FLUSH, 8'h00);
    check8(8'(n_pop), 8'h01);
    check8(8'(n_rel), 8'h01);
    check8(8'(n_flush), 8'h01);
  endtask : t_live
  task automatic t_axis;
    ax = 12'h8a5;
    hp = 12'h7f3;
    accreg_master_model_i.wr(`ACCREG_MAIN_CFG_A, 8'h00);
    accreg_master_model_i.wr(`ACCREG_RATE_CFG, 8'h00);
    accreg_master_model_i.wr(`ACCREG_MAIN_CFG_A, 8'hc2);
    rchk(`ACCREG_X_AC_HI, 8'h8a);
    rchk(`ACCREG_X_AC_LO, 8'h50);
    rchk(`ACCREG_Y_AC_HI, 8'h75);
    rchk(`ACCREG_X_HP_HI, 8'h7f);
    rchk(`ACCREG_Z_HP_LO, 8'hc0);
    accreg_master_model_i.wr(`ACCREG_MAIN_CFG_A, 8'h00);
    ax = 12'h800;
    accreg_master_model_i.hold(100);
    rchk(`ACCREG_X_AC_HI, 8'h8a);
    accreg_master_model_i.wr(`ACCREG_MAIN_CFG_A, 8'h80);
    rchk(`ACCREG_X_AC_HI, 8'h80);
    rchk(`ACCREG_X_AC_LO, 8'h00);
    rchk(`ACCREG_X_HP_HI, 8'h00);
  endtask : t_axis
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  // Cuts a hang short, far beyond the expected run
  initial begin
    #400_000;
    err_total++;
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    ax = '0;
    hp = '0;
    live = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    t_reset_map();
    t_rw_table();
    t_live();
    t_axis();
    // Reset in mid-run must clear stored settings and leave the port usable
    accreg_master_model_i.wr(`ACCREG_RATE_CFG, 8'h05);
    srst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    rchk(`ACCREG_RATE_CFG, 8'h00);
    rchk(`ACCREG_PART_ID, PID);
    give_verdict();
  end
endmodule : accreg_top_bench
`default_nettype wire
